// File: logic/ldorc_regs.sv
// Operation
// - each output has a 6-bit voltage code, top two bits read zero
// - control bit 7 written 1 turns output on, 0 off; reads back
// - discharge drive asserted only in shutdown and with discharge bit set
// - output faults raise interrupt only while fault irq enable is set
// - power-good bit reads live comparator level
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module ldorc_regs #(
  parameter int N = 5
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [N-1:0] power_good,
  input  wire logic [N-1:0] fault,
  output logic [N-1:0]      out_enable,
  output logic [N-1:0]      discharge_on,
  output logic [N*6-1:0]    output_voltage_code,
  output logic              irq
);
  // =====================================================
  // register storage
  logic [5:0]   vcode_reg   [N];
  logic [N-1:0] enable_reg;
  logic [N-1:0] shutdown_discharge_enable_reg;
  logic [N-1:0] fault_irq_enable_reg;
  logic [N-1:0] mask_reg;
  logic [N-1:0] fault_q_reg;
  logic [N-1:0] discharge_reg;
  logic [N-1:0] oen_reg;
  logic [N*6-1:0] vout_reg;

  // =====================================================
  // address decode
  typedef enum logic [1:0] {LDORC_K_VOLT, LDORC_K_CTRL, LDORC_K_STAT, LDORC_K_MASK} ldorc_kind_e;
  typedef struct packed {
    logic        hit;
    ldorc_kind_e kind;
    logic [2:0]  ch;
  } ldorc_dec_s;

  function automatic ldorc_dec_s ldorc_decode(input logic [11:0] a);
    ldorc_dec_s d;
    d = '{hit: 1'b0, kind: LDORC_K_VOLT, ch: 3'h0};
    if (a[1:0] == 2'h0) begin
      case (a[9:2])
        ldorc_pkg::IDX_OUT6_VOLTAGE:  d = '{1'b1, LDORC_K_VOLT, 3'h0};
        ldorc_pkg::IDX_OUT6_CONTROL:  d = '{1'b1, LDORC_K_CTRL, 3'h0};
        ldorc_pkg::IDX_OUT7_VOLTAGE:  d = '{1'b1, LDORC_K_VOLT, 3'h1};
        ldorc_pkg::IDX_OUT7_CONTROL:  d = '{1'b1, LDORC_K_CTRL, 3'h1};
        ldorc_pkg::IDX_OUT8_VOLTAGE:  d = '{1'b1, LDORC_K_VOLT, 3'h2};
        ldorc_pkg::IDX_OUT8_CONTROL:  d = '{1'b1, LDORC_K_CTRL, 3'h2};
        ldorc_pkg::IDX_OUT9_VOLTAGE:  d = '{1'b1, LDORC_K_VOLT, 3'h3};
        ldorc_pkg::IDX_OUT9_CONTROL:  d = '{1'b1, LDORC_K_CTRL, 3'h3};
        ldorc_pkg::IDX_OUT10_VOLTAGE: d = '{1'b1, LDORC_K_VOLT, 3'h4};
        ldorc_pkg::IDX_OUT10_CONTROL: d = '{1'b1, LDORC_K_CTRL, 3'h4};
        ldorc_pkg::IDX_IRQ_STATUS:    d = '{1'b1, LDORC_K_STAT, 3'h0};
        ldorc_pkg::IDX_IRQ_MASK:      d = '{1'b1, LDORC_K_MASK, 3'h0};
        default:                      d.hit = 1'b0;
      endcase
    end
    if (a[11:10] != 2'h0) begin
      d.hit = 1'b0;
    end
    if (d.hit && (d.kind == LDORC_K_VOLT || d.kind == LDORC_K_CTRL)
        && d.ch > 3'(N - 1)) begin
      d.hit = 1'b0;
    end
    return d;
  endfunction

  // =====================================================
  // write channel
  logic [11:0] awaddr_reg;
  logic        aw_held_reg;
  logic [7:0]  wbyte_reg;
  logic        wbyte_en_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        do_write;
  ldorc_dec_s  wdec;

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wdec     = ldorc_decode(awaddr_reg);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_held_reg  <= 1'b0;
      awaddr_reg   <= '0;
      w_held_reg   <= 1'b0;
      wbyte_reg    <= '0;
      wbyte_en_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wbyte_reg    <= s_axi_wdata[7:0];
        wbyte_en_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  logic awready_reg;
  logic wready_reg;
  logic b_busy;

  assign b_busy = do_write || (bvalid_reg && !s_axi_bready);

  // readies registered, low while a transfer is held or answered
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= !(s_axi_awvalid && awready_reg) && !aw_held_reg && !b_busy;
      wready_reg  <= !(s_axi_wvalid && wready_reg) && !w_held_reg && !b_busy;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ldorc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wdec.hit ? ldorc_pkg::RESP_OKAY : ldorc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // =====================================================
  // register updates
  logic wr_ok;
  assign wr_ok = do_write && wdec.hit && wbyte_en_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < N; i++) begin
        vcode_reg[i] <= ldorc_pkg::RST_VCODE;
      end
    end else if (wr_ok && wdec.kind == LDORC_K_VOLT) begin
      vcode_reg[wdec.ch] <= wbyte_reg[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      enable_reg                    <= '0;
      shutdown_discharge_enable_reg <= '0;
      fault_irq_enable_reg          <= '0;
    end else if (wr_ok && wdec.kind == LDORC_K_CTRL) begin
      enable_reg[wdec.ch]                    <= wbyte_reg[ldorc_pkg::BIT_ENABLE];
      shutdown_discharge_enable_reg[wdec.ch] <= wbyte_reg[ldorc_pkg::BIT_DISCHARGE];
      fault_irq_enable_reg[wdec.ch]          <= wbyte_reg[ldorc_pkg::BIT_FAULT_IE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mask_reg <= ldorc_pkg::RST_IRQ_MASK[N-1:0];
    end else if (wr_ok && wdec.kind == LDORC_K_MASK) begin
      mask_reg <= wbyte_reg[N-1:0];
    end
  end

  // =====================================================
  // outputs to the regulators
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      discharge_reg <= '0;
      oen_reg       <= '0;
      vout_reg      <= '0;
    end else begin
      // enable and discharge from one sample, never both high
      oen_reg       <= enable_reg;
      discharge_reg <= ~enable_reg & shutdown_discharge_enable_reg;
      for (int i = 0; i < N; i++) begin
        vout_reg[i*6 +: 6] <= vcode_reg[i];
      end
    end
  end

  assign out_enable          = oen_reg;
  assign discharge_on        = discharge_reg;
  assign output_voltage_code = vout_reg;

  // =====================================================
  // fault events and interrupt
  ldorc_irq_if #(.N(N)) irq_bus ();
  logic rd_stat;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fault_q_reg <= '0;
    end else begin
      fault_q_reg <= fault;
    end
  end

  assign irq_bus.event_set = fault & ~fault_q_reg & fault_irq_enable_reg;
  assign irq_bus.mask      = mask_reg;
  assign irq_bus.status_rd = rd_stat;

  ldorc_irq #(.N(N)) u_irq (
    .core_clk (core_clk),
    .resetn   (resetn),
    .bus      (irq_bus)
  );

  assign irq = irq_bus.irq;

  // =====================================================
  // read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  ldorc_dec_s  rdec;
  logic [7:0]  rbyte;
  logic        arready_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arready_reg <= 1'b0;
    end else begin
      arready_reg <= !(s_axi_arvalid && arready_reg) && !(rvalid_reg && !s_axi_rready);
    end
  end

  assign rdec          = ldorc_decode(s_axi_araddr);
  assign s_axi_arready = arready_reg;
  assign rd_stat       = s_axi_arvalid && s_axi_arready && rdec.hit
                         && rdec.kind == LDORC_K_STAT;

  always_comb begin
    rbyte = 8'h00;
    case (rdec.kind)
      LDORC_K_VOLT: rbyte = {2'b00, vcode_reg[rdec.ch]};
      LDORC_K_CTRL: rbyte = {enable_reg[rdec.ch], 4'h0,
                             shutdown_discharge_enable_reg[rdec.ch],
                             fault_irq_enable_reg[rdec.ch],
                             power_good[rdec.ch]};
      LDORC_K_STAT: rbyte = 8'(irq_bus.status);
      LDORC_K_MASK: rbyte = 8'(mask_reg);
      default:      rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= ldorc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdec.hit ? {24'h000000, rbyte} : 32'h00000000;
      rresp_reg  <= rdec.hit ? ldorc_pkg::RESP_OKAY : ldorc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // =====================================================
  // checks
  property p_discharge;
    @(posedge core_clk) disable iff (!resetn)
      ##1 discharge_on == $past(~enable_reg & shutdown_discharge_enable_reg);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge mismatch");

  property p_no_discharge_on;
    @(posedge core_clk) disable iff (!resetn)
      (discharge_on & out_enable) == '0;
  endproperty
  a_no_discharge_on: assert property (p_no_discharge_on) else $error("discharge while on");

  property p_fault_gate;
    @(posedge core_clk) disable iff (!resetn)
      (irq_bus.status & ~$past(irq_bus.status) & ~$past(fault_irq_enable_reg)) == '0;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault event while disabled");

  property p_ctrl_write;
    @(posedge core_clk) disable iff (!resetn)
      (wr_ok && wdec.kind == LDORC_K_CTRL)
        |=> ##1 out_enable[$past(wdec.ch, 2)] == $past(wbyte_reg[7], 2);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable not written");

  property p_vcode_write;
    @(posedge core_clk) disable iff (!resetn)
      (wr_ok && wdec.kind == LDORC_K_VOLT)
        |=> vcode_reg[$past(wdec.ch)] == $past(wbyte_reg[5:0]);
  endproperty
  a_vcode_write: assert property (p_vcode_write) else $error("code not written");

  property p_rd_pgood;
    @(posedge core_clk) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready && rdec.hit && rdec.kind == LDORC_K_CTRL)
        |=> s_axi_rdata[0] == $past(power_good[rdec.ch]) && s_axi_rvalid;
  endproperty
  a_rd_pgood: assert property (p_rd_pgood) else $error("power good readback wrong");

  property p_rd_reserved;
    @(posedge core_clk) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready && rdec.hit && rdec.kind == LDORC_K_CTRL)
        |=> s_axi_rdata[6:3] == 4'h0 && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits nonzero");

  property p_rd_vreserved;
    @(posedge core_clk) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready && rdec.hit && rdec.kind == LDORC_K_VOLT)
        |=> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[5:0] == $past(vcode_reg[rdec.ch]);
  endproperty
  a_rd_vreserved: assert property (p_rd_vreserved) else $error("voltage readback wrong");
endmodule

// File: logic/ldorc_pkg.sv
package ldorc_pkg;
  // printed offsets are not all multiples of four: index form, byte = 4 * index
  localparam int unsigned N_OUT = 5;
  localparam logic [7:0] IDX_OUT6_VOLTAGE  = 8'h58;
  localparam logic [7:0] IDX_OUT6_CONTROL  = 8'h59;
  localparam logic [7:0] IDX_OUT7_VOLTAGE  = 8'h60;
  localparam logic [7:0] IDX_OUT7_CONTROL  = 8'h61;
  localparam logic [7:0] IDX_OUT8_VOLTAGE  = 8'h68;
  localparam logic [7:0] IDX_OUT8_CONTROL  = 8'h69;
  localparam logic [7:0] IDX_OUT9_VOLTAGE  = 8'h70;
  localparam logic [7:0] IDX_OUT9_CONTROL  = 8'h71;
  localparam logic [7:0] IDX_OUT10_VOLTAGE = 8'h80;
  localparam logic [7:0] IDX_OUT10_CONTROL = 8'h81;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'hF1;
  localparam int unsigned BIT_ENABLE    = 7;
  localparam int unsigned BIT_DISCHARGE = 2;
  localparam int unsigned BIT_FAULT_IE  = 1;
  localparam int unsigned BIT_PGOOD     = 0;
  localparam int unsigned VCODE_W       = 6;
  localparam logic [5:0] RST_VCODE    = 6'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// File: logic/ldorc_irq_if.sv
`timescale 1ns/1ns
interface ldorc_irq_if #(parameter int N = 5);
  logic [N-1:0] event_set;
  logic         status_rd;
  logic [N-1:0] mask;
  logic [N-1:0] status;
  logic         irq;
  modport core (output event_set, output status_rd, output mask, input status, input irq);
  modport unit (input event_set, input status_rd, input mask, output status, output irq);
endinterface

// File: logic/ldorc_irq.sv
`timescale 1ns/1ns
module ldorc_irq #(
  parameter int N = 5
) (
  input  wire logic   core_clk,
  input  wire logic   resetn,
  ldorc_irq_if.unit   bus
);
  logic [N-1:0] status_reg;
  logic         irq_reg;

  // =====================================================
  // sticky status, set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_reg <= '0;
    end else if (bus.status_rd) begin
      status_reg <= bus.event_set;
    end else begin
      status_reg <= status_reg | bus.event_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & bus.mask);
    end
  end

  assign bus.status = status_reg;
  assign bus.irq    = irq_reg;
endmodule

// File: sim/ldorc_tb.sv
`timescale 1ns/1ns
// ======================================
// bench for the regulator register bank
module testbench;
  logic        core_clk;
  logic        resetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [4:0]  pg;
  logic [4:0]  fault;
  logic [4:0]  oen;
  logic [4:0]  dis_on;
  logic [29:0] vcode;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          n_mismatch;
  int          checks;
  logic [7:0]  vi [5] = '{ldorc_pkg::IDX_OUT6_VOLTAGE, ldorc_pkg::IDX_OUT7_VOLTAGE,
    ldorc_pkg::IDX_OUT8_VOLTAGE, ldorc_pkg::IDX_OUT9_VOLTAGE, ldorc_pkg::IDX_OUT10_VOLTAGE};
  logic [7:0]  cw [4] = '{8'hFE, 8'h7C, 8'h84, 8'h00};
  logic [7:0]  cr [4] = '{8'h86, 8'h04, 8'h84, 8'h00};

  ldorc_regs #(.N(5)) DUT (
    .core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_good(pg), .fault(fault), .out_enable(oen),
    .discharge_on(dis_on), .output_voltage_code(vcode), .irq(irq));

  // ======================================
  // bus and compare tasks
  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit b;
    b = 0;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= {24'h000000, d};
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        b = 1;
        rs = bresp;
        bready <= 1'h0;
      end
    end
  endtask

  task automatic rdr(input logic [11:0] a);
    bit b;
    b = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!b) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        b = 1;
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
      end
    end
  endtask

  task automatic wirq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    chk("irq", 32'(e), 32'(irq));
  endtask

  // ======================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      rdr(adr(vi[i]));
      chk("voltage reset", 32'h0, rd);
      rdr(adr(vi[i] + 8'h01));
      chk("control reset", 32'h0, rd);
    end
    chk("enable pins reset", 32'h0, 32'(oen));
    $display("test reset done");
  endtask

  task automatic t_vcode;
    for (int i = 0; i < 5; i++) begin
      wr(adr(vi[i]), 8'hC0);
      rdr(adr(vi[i]));
      chk("reserved voltage bits", 32'h0, rd);
      wr(adr(vi[i]), 8'hFF);
      chk("write resp", 32'(ldorc_pkg::RESP_OKAY), 32'(rs));
      rdr(adr(vi[i]));
      chk("voltage code", 32'h3F, rd);
      chk("read resp", 32'(ldorc_pkg::RESP_OKAY), 32'(rs));
      chk("voltage pins", 32'h3F, 32'(vcode[i*6 +: 6]));
    end
    $display("test voltage done");
  endtask

  task automatic t_ctrl;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 4; k++) begin
        wr(adr(vi[i] + 8'h01), cw[k]);
        rdr(adr(vi[i] + 8'h01));
        chk("control", 32'(cr[k]), rd);
        repeat (2) @(posedge core_clk);
        chk("enable pin", 32'(cr[k][7]), 32'(oen[i]));
        chk("discharge pin", 32'(cr[k][2] & !cr[k][7]), 32'(dis_on[i]));
      end
    end
    $display("test control done");
  endtask

  task automatic t_pg;
    logic [4:0] p [2] = '{5'h16, 5'h09};
    for (int k = 0; k < 2; k++) begin
      pg <= p[k];
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 5; i++) begin
        rdr(adr(vi[i] + 8'h01));
        chk("power good", 32'(p[k][i]), rd);
      end
    end
    $display("test power good done");
  endtask

  task automatic t_irq;
    wr(adr(ldorc_pkg::IDX_IRQ_MASK), 8'h1F);
    fault <= 5'h01;
    repeat (10) @(posedge core_clk);
    chk("irq off", 32'h0, 32'(irq));
    rdr(adr(ldorc_pkg::IDX_IRQ_STATUS));
    chk("status off", 32'h0, rd);
    fault <= 5'h00;
    wr(adr(vi[0] + 8'h01), 8'h02);
    fault <= 5'h01;
    wirq(1'h1);
    rdr(adr(ldorc_pkg::IDX_IRQ_STATUS));
    chk("status set", 32'h1, rd);
    fault <= 5'h00;
    wirq(1'h0);
    rdr(adr(ldorc_pkg::IDX_IRQ_STATUS));
    chk("status cleared", 32'h0, rd);
    wr(adr(vi[1] + 8'h01), 8'h02);
    wr(adr(ldorc_pkg::IDX_IRQ_MASK), 8'h1D);
    fault <= 5'h02;
    repeat (10) @(posedge core_clk);
    chk("irq masked", 32'h0, 32'(irq));
    rdr(adr(ldorc_pkg::IDX_IRQ_STATUS));
    chk("status masked", 32'h2, rd);
    fault <= 5'h00;
    $display("test interrupt done");
  endtask

  task automatic t_bad;
    rdr(12'h168);
    chk("unmapped read resp", 32'(ldorc_pkg::RESP_SLVERR), 32'(rs));
    chk("unmapped read data", 32'h0, rd);
    wr(12'h161, 8'hFF);
    chk("misaligned write resp", 32'(ldorc_pkg::RESP_SLVERR), 32'(rs));
    wstrb <= 4'h0;
    wr(adr(vi[0]), 8'h15);
    chk("strobe off write resp", 32'(ldorc_pkg::RESP_OKAY), 32'(rs));
    wstrb <= 4'hF;
    rdr(adr(vi[0]));
    chk("voltage kept", 32'h3F, rd);
    $display("test unmapped done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out;
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    wstrb = 4'hF;
    {pg, fault} = 10'h000;
    repeat (20) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset;
    t_vcode;
    t_ctrl;
    t_pg;
    t_irq;
    t_bad;
    close_out;
  end
endmodule
